// *** rtl/twsx_alu.sv ***
// operand unit: exclusive-or, flags, zero test and file address
`include "twsx_consts.svh"

module twsx_alu (
   // operands
   input wire logic [7:0] acc,
   input wire logic [7:0] operand,
   // results
   output logic [7:0] result,
   output logic neg,
   output logic zero,
   output logic operand_zero,
   // file addressing
   input wire logic [7:0] file_sel,
   input wire logic bank_sel,
   input wire logic [`TWSX_BANK_W-1:0] bank,
   output logic [`TWSX_DADDR_W-1:0] addr
);
   import twsx_pkg::*;

   // ------------------------------------------------------------------
   // data path
   // ------------------------------------------------------------------
   // exclusive-or and its flags
   assign result = acc ^ operand;
   assign neg = result[7];
   assign zero = (result == `TWSX_ZERO_BYTE);
   assign operand_zero = (operand == `TWSX_ZERO_BYTE);

   // ------------------------------------------------------------------
   // bank selection
   // ------------------------------------------------------------------
   // access bank: low half of page 0 or top half of page 15
   wire [`TWSX_BANK_W-1:0] acc_bank = file_sel[`TWSX_ACC_SPLIT_BIT] ?
      `TWSX_ACC_HI_BANK : `TWSX_ACC_LO_BANK;
   // bank bit clear ignores the bank select register
   wire [`TWSX_BANK_W-1:0] eff_bank = bank_sel ? bank : acc_bank;
   assign addr = {eff_bank, file_sel};

endmodule

// *** rtl/twsx_consts.svh ***
// constants of the table write, skip and exclusive-or execution unit
`ifndef TWSX_CONSTS_SVH
`define TWSX_CONSTS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define TWSX_PTR_W 21
`define TWSX_DADDR_W 12
`define TWSX_BANK_W 4
`define TWSX_REG_AW 3

// ----------------------------------------------------------------------
// opcode patterns and instruction fields
// ----------------------------------------------------------------------
`define TWSX_OP_XOR_LIT 8'h0A
`define TWSX_OP_XOR_FILE 6'h06
`define TWSX_OP_TEST_SKIP 7'h33
`define TWSX_OP_TABLE_WR 14'h0003
`define TWSX_D_BIT 9
`define TWSX_A_BIT 8
`define TWSX_ACC_SPLIT_BIT 7
`define TWSX_ACC_HI_BANK 4'hF
`define TWSX_ACC_LO_BANK 4'h0

// table write pointer modes, low two opcode bits
`define TWSX_TBL_NONE 2'h0
`define TWSX_TBL_POSTINC 2'h1
`define TWSX_TBL_POSTDEC 2'h2
`define TWSX_TBL_PREINC 2'h3

// ----------------------------------------------------------------------
// instruction cycle phases
// ----------------------------------------------------------------------
`define TWSX_Q1 2'h0
`define TWSX_Q2 2'h1
`define TWSX_Q3 2'h2
`define TWSX_Q4 2'h3
`define TWSX_Q_STEP 2'h1

// ----------------------------------------------------------------------
// register port indices, status bits, reset values
// ----------------------------------------------------------------------
`define TWSX_REG_WORK 3'h0
`define TWSX_REG_STATUS 3'h1
`define TWSX_REG_BANK 3'h2
`define TWSX_REG_TLAT 3'h3
`define TWSX_REG_TPTR_L 3'h4
`define TWSX_REG_TPTR_H 3'h5
`define TWSX_REG_TPTR_U 3'h6
`define TWSX_REG_STATE 3'h7
`define TWSX_ST_Z 0
`define TWSX_ST_N 1
`define TWSX_RST_BYTE 8'h00
`define TWSX_RST_BANK 4'h0
`define TWSX_RST_PTR 21'h000000
`define TWSX_PTR_STEP 21'h000001
`define TWSX_ZERO_BYTE 8'h00

`endif

// *** rtl/twsx_exec.sv ***
// execution unit for table write, test-skip and exclusive-or opcodes
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`include "twsx_consts.svh"

module twsx_exec (
   // clock, reset and enable
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   // instruction issue
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR,
   input wire logic INSTR_NEXT_TWO_WORD,
   output logic INSTR_READY,
   output logic DISCARD,
   // data memory
   output twsx_pkg::twsx_dmem_req_t DMEM_REQ,
   input wire logic [7:0] DMEM_RDATA,
   // program memory
   output twsx_pkg::twsx_pmem_req_t PMEM_REQ,
   // register port
   input wire logic [`TWSX_REG_AW-1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA
);
   import twsx_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   twsx_state_t state_r, state_nxt;
   logic [1:0] q_r, q_nxt;
   logic [15:0] instr_r;
   logic two_word_r;
   logic skip_r, skip_nxt;
   logic [7:0] work_r, work_nxt;
   logic [7:0] tlat_r, tlat_nxt;
   logic [`TWSX_BANK_W-1:0] bank_r, bank_nxt;
   logic [`TWSX_PTR_W-1:0] tptr_r, tptr_nxt;
   logic n_r, n_nxt;
   logic z_r, z_nxt;
   logic ready_r;
   logic discard_r;
   logic [7:0] rdata_r, rdata_nxt;
   twsx_dmem_req_t dmem_r, dmem_nxt;
   twsx_pmem_req_t pmem_r, pmem_nxt;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   // phase and state qualifiers
   wire accept = (state_r == S_IDLE) && INSTR_VALID;
   wire in_exec = (state_r == S_EXEC);
   wire in_tblw = (state_r == S_TBLW);
   wire ph_q1 = (q_r == `TWSX_Q1);
   wire ph_q3 = (q_r == `TWSX_Q3);
   wire ph_end = (q_r == `TWSX_Q4);

   // opcode classes of the latched instruction
   wire dec_xor_lit = (instr_r[15:8] == `TWSX_OP_XOR_LIT);
   wire dec_xor_file = (instr_r[15:10] == `TWSX_OP_XOR_FILE);
   wire dec_test_skip = (instr_r[15:9] == `TWSX_OP_TEST_SKIP);
   wire dec_table_wr = (instr_r[15:2] == `TWSX_OP_TABLE_WR);
   wire dec_fileop = dec_xor_file || dec_test_skip;
   wire [1:0] tbl_mode = instr_r[1:0];
   wire dest_file = instr_r[`TWSX_D_BIT];
   wire bank_bit = instr_r[`TWSX_A_BIT];

   // ------------------------------------------------------------------
   // operand unit
   // ------------------------------------------------------------------
   logic [7:0] alu_result;
   logic alu_neg;
   logic alu_zero;
   logic opnd_zero;
   logic [`TWSX_DADDR_W-1:0] file_addr;
   wire [7:0] alu_operand = dec_xor_lit ? instr_r[7:0] : DMEM_RDATA;

   twsx_alu twsx_alu_inst (
      .acc(work_r),
      .operand(alu_operand),
      .result(alu_result),
      .neg(alu_neg),
      .zero(alu_zero),
      .operand_zero(opnd_zero),
      .file_sel(instr_r[7:0]),
      .bank_sel(bank_bit),
      .bank(bank_r),
      .addr(file_addr)
   );

   // ------------------------------------------------------------------
   // execution events
   // ------------------------------------------------------------------
   // result lands at the end of the process phase
   wire exec_q3 = in_exec && ph_q3;
   wire wr_work = exec_q3 &&
      (dec_xor_lit || (dec_xor_file && !dest_file));
   wire wr_file = exec_q3 && dec_xor_file && dest_file;
   wire upd_flags = exec_q3 && (dec_xor_lit || dec_xor_file);
   // a zero operand arms the skip; flags are left alone
   wire skip_set = exec_q3 && dec_test_skip && opnd_zero;

   // pointer steps: before the write or after it
   wire pre_step = in_exec && ph_end && dec_table_wr &&
      (tbl_mode == `TWSX_TBL_PREINC);
   wire post_inc = in_tblw && ph_end &&
      (tbl_mode == `TWSX_TBL_POSTINC);
   wire post_dec = in_tblw && ph_end &&
      (tbl_mode == `TWSX_TBL_POSTDEC);
   wire [`TWSX_PTR_W-1:0] tptr_inc = tptr_r + `TWSX_PTR_STEP;
   wire [`TWSX_PTR_W-1:0] tptr_dec = tptr_r - `TWSX_PTR_STEP;

   // ------------------------------------------------------------------
   // register port decode
   // ------------------------------------------------------------------
   wire bw_work = REG_WR && (REG_ADDR == `TWSX_REG_WORK);
   wire bw_status = REG_WR && (REG_ADDR == `TWSX_REG_STATUS);
   wire bw_bank = REG_WR && (REG_ADDR == `TWSX_REG_BANK);
   wire bw_tlat = REG_WR && (REG_ADDR == `TWSX_REG_TLAT);
   wire bw_tptr_l = REG_WR && (REG_ADDR == `TWSX_REG_TPTR_L);
   wire bw_tptr_h = REG_WR && (REG_ADDR == `TWSX_REG_TPTR_H);
   wire bw_tptr_u = REG_WR && (REG_ADDR == `TWSX_REG_TPTR_U);

   // read selection; unused bits read as zero
   wire [7:0] status_rd = {6'h00, n_r, z_r};
   wire [7:0] bank_rd = {4'h0, bank_r};
   wire [7:0] tptr_u_rd = {3'h0, tptr_r[20:16]};
   wire [7:0] state_rd = {skip_r, state_r, q_r};
   wire [7:0] reg_sel =
      (REG_ADDR == `TWSX_REG_WORK) ? work_r :
      (REG_ADDR == `TWSX_REG_STATUS) ? status_rd :
      (REG_ADDR == `TWSX_REG_BANK) ? bank_rd :
      (REG_ADDR == `TWSX_REG_TLAT) ? tlat_r :
      (REG_ADDR == `TWSX_REG_TPTR_L) ? tptr_r[7:0] :
      (REG_ADDR == `TWSX_REG_TPTR_H) ? tptr_r[15:8] :
      (REG_ADDR == `TWSX_REG_TPTR_U) ? tptr_u_rd : state_rd;

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   // one instruction cycle is four phases; extra cycles follow
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE: begin
            if (accept) begin
               state_nxt = S_EXEC;
            end
         end
         S_EXEC: begin
            if (ph_end) begin
               if (dec_table_wr) begin
                  state_nxt = S_TBLW;
               end else if (dec_test_skip && skip_r) begin
                  state_nxt = S_SKIP1;
               end else begin
                  state_nxt = S_IDLE;
               end
            end
         end
         S_TBLW: begin
            if (ph_end) begin
               state_nxt = S_IDLE;
            end
         end
         S_SKIP1: begin
            if (ph_end) begin
               // second dead cycle for a two-word victim
               state_nxt = two_word_r ? S_SKIP2 : S_IDLE;
            end
         end
         S_SKIP2: begin
            if (ph_end) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // phase counter rests at the first phase while idle
   assign q_nxt = (state_r == S_IDLE) ? `TWSX_Q1 : q_r + `TWSX_Q_STEP;

   // skip flag is armed at process time, cleared on a new issue
   assign skip_nxt = accept ? 1'b0 : (skip_set ? 1'b1 : skip_r);

   // ------------------------------------------------------------------
   // architectural registers
   // ------------------------------------------------------------------
   // execution updates take precedence over a port write
   always_comb begin
      work_nxt = bw_work ? REG_WDATA : work_r;
      if (wr_work) begin
         work_nxt = alu_result;
      end
      n_nxt = bw_status ? REG_WDATA[`TWSX_ST_N] : n_r;
      z_nxt = bw_status ? REG_WDATA[`TWSX_ST_Z] : z_r;
      if (upd_flags) begin
         n_nxt = alu_neg;
         z_nxt = alu_zero;
      end
      bank_nxt = bw_bank ? REG_WDATA[`TWSX_BANK_W-1:0] : bank_r;
      tlat_nxt = bw_tlat ? REG_WDATA : tlat_r;
      tptr_nxt = tptr_r;
      if (bw_tptr_l) begin
         tptr_nxt[7:0] = REG_WDATA;
      end
      if (bw_tptr_h) begin
         tptr_nxt[15:8] = REG_WDATA;
      end
      if (bw_tptr_u) begin
         tptr_nxt[20:16] = REG_WDATA[4:0];
      end
      if (pre_step || post_inc) begin
         tptr_nxt = tptr_inc;
      end else if (post_dec) begin
         tptr_nxt = tptr_dec;
      end
   end

   // ------------------------------------------------------------------
   // memory requests
   // ------------------------------------------------------------------
   // file read in the second phase, file write in the fourth
   always_comb begin
      dmem_nxt = dmem_r;
      dmem_nxt.rd = in_exec && ph_q1 && dec_fileop;
      dmem_nxt.wr = wr_file;
      if (in_exec && ph_q1 && dec_fileop) begin
         dmem_nxt.addr = file_addr;
      end
      if (wr_file) begin
         dmem_nxt.wdata = alu_result;
      end
   end

   // program write in the second phase of the second cycle
   always_comb begin
      pmem_nxt = pmem_r;
      pmem_nxt.wr = in_tblw && ph_q1;
      if (in_tblw && ph_q1) begin
         // word address plus byte select from the pointer
         pmem_nxt.word_addr = tptr_r[`TWSX_PTR_W-1:1];
         pmem_nxt.high_byte = tptr_r[0];
         pmem_nxt.data = tlat_r;
      end
   end

   // read data stands only in the cycle after the strobe
   assign rdata_nxt = REG_RD ? reg_sel : `TWSX_ZERO_BYTE;

   // ------------------------------------------------------------------
   // flip-flops
   // ------------------------------------------------------------------
   // sequencing and instruction latch
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_r <= S_IDLE;
         q_r <= `TWSX_Q1;
         instr_r <= 16'h0000;
         two_word_r <= 1'b0;
         skip_r <= 1'b0;
      end else if (CE) begin
         state_r <= state_nxt;
         q_r <= q_nxt;
         skip_r <= skip_nxt;
         if (accept) begin
            instr_r <= INSTR;
            two_word_r <= INSTR_NEXT_TWO_WORD;
         end
      end
   end

   // working, status, bank, latch and pointer registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         work_r <= `TWSX_RST_BYTE;
         n_r <= 1'b0;
         z_r <= 1'b0;
         bank_r <= `TWSX_RST_BANK;
         tlat_r <= `TWSX_RST_BYTE;
         tptr_r <= `TWSX_RST_PTR;
      end else if (CE) begin
         work_r <= work_nxt;
         n_r <= n_nxt;
         z_r <= z_nxt;
         bank_r <= bank_nxt;
         tlat_r <= tlat_nxt;
         tptr_r <= tptr_nxt;
      end
   end

   // registered outputs
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ready_r <= 1'b1;
         discard_r <= 1'b0;
         rdata_r <= `TWSX_ZERO_BYTE;
         dmem_r <= '0;
         pmem_r <= '0;
      end else if (CE) begin
         ready_r <= (state_nxt == S_IDLE);
         discard_r <= (state_nxt == S_SKIP1) ||
            (state_nxt == S_SKIP2);
         rdata_r <= rdata_nxt;
         dmem_r <= dmem_nxt;
         pmem_r <= pmem_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign INSTR_READY = ready_r;
   assign DISCARD = discard_r;
   assign DMEM_REQ = dmem_r;
   assign PMEM_REQ = pmem_r;
   assign REG_RDATA = rdata_r;

endmodule

// *** rtl/twsx_pkg.sv ***
// types shared by the execution unit and its operand unit
`include "twsx_consts.svh"

package twsx_pkg;

   // ------------------------------------------------------------------
   // sequencer states, one-hot
   // ------------------------------------------------------------------
   typedef enum logic [4:0] {
      S_IDLE  = 5'h01,
      S_EXEC  = 5'h02,
      S_TBLW  = 5'h04,
      S_SKIP1 = 5'h08,
      S_SKIP2 = 5'h10
   } twsx_state_t;

   // ------------------------------------------------------------------
   // memory request carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [`TWSX_DADDR_W-1:0] addr;
      logic [7:0] wdata;
   } twsx_dmem_req_t;

   typedef struct packed {
      logic wr;
      logic [`TWSX_PTR_W-2:0] word_addr;
      logic high_byte;
      logic [7:0] data;
   } twsx_pmem_req_t;

endpackage

// *** verification/testbench.sv ***
// self-checking bench of the table write, skip and xor execution unit
`include "twsx_consts.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------------
   // stimulus, responses and memory models
   // ------------------------------------------------------------------
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic CE = 1'b1;
   logic INSTR_VALID = 1'b0;
   logic [15:0] INSTR = 16'h0000;
   logic INSTR_NEXT_TWO_WORD = 1'b0;
   logic [2:0] REG_ADDR = 3'h0;
   logic [7:0] REG_WDATA = 8'h00;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [7:0] DMEM_RDATA = 8'h00;
   logic INSTR_READY;
   logic DISCARD;
   logic [7:0] REG_RDATA;
   twsx_pkg::twsx_dmem_req_t DMEM_REQ;
   twsx_pkg::twsx_pmem_req_t PMEM_REQ;
   logic [7:0] dmem [0:4095];
   logic [19:0] wr_last;
   logic [28:0] pm_last;
   int wr_cnt = 0;
   int err_count = 0;
   int check_count = 0;

   always #25 CLK = ~CLK;

   twsx_exec twsx_exec_inst (
      .CLK, .RESET, .CE, .INSTR_VALID, .INSTR, .INSTR_NEXT_TWO_WORD,
      .INSTR_READY, .DISCARD, .DMEM_REQ, .DMEM_RDATA, .PMEM_REQ,
      .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA
   );

   // data memory answers a read next cycle, scrambles when idle
   always @(posedge CLK) begin
      DMEM_RDATA <= DMEM_REQ.rd ? dmem[DMEM_REQ.addr] : ~DMEM_RDATA;
      if (DMEM_REQ.wr) begin
         dmem[DMEM_REQ.addr] <= DMEM_REQ.wdata;
         wr_last <= {DMEM_REQ.addr, DMEM_REQ.wdata};
         wr_cnt <= wr_cnt + 1;
      end
      if (PMEM_REQ.wr)
         pm_last <= {PMEM_REQ.word_addr, PMEM_REQ.high_byte, PMEM_REQ.data};
   end

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic reg_chk(input logic [2:0] a, input logic [7:0] e);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      @(negedge CLK);
      chk(REG_RDATA, e, "register read");
      @(negedge CLK);
      chk(REG_RDATA, 8'h00, "read data after its cycle");
   endtask

   // issue one opcode, count cycles to ready and discarded cycles
   task automatic run(input logic [15:0] op, input logic tw,
      input int cyc, disc);
      int n;
      int d;
      n = 0;
      d = 0;
      @(posedge CLK);
      INSTR <= op;
      INSTR_NEXT_TWO_WORD <= tw;
      INSTR_VALID <= 1'b1;
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      do begin
         @(negedge CLK);
         n++;
         if (DISCARD === 1'b1) d++;
      end while (INSTR_READY !== 1'b1 && n < 40);
      chk(n, cyc, "cycles");
      chk(d, disc, "discarded clocks");
   endtask

   task automatic xwf(input logic [7:0] f, input logic d, a,
      input logic [11:0] adr, input logic [7:0] m, r, w, st);
      int c;
      c = wr_cnt;
      dmem[adr] = m;
      run({`TWSX_OP_XOR_FILE, d, a, f}, 1'b0, 5, 0);
      chk(wr_cnt - c, d, "file writes");
      if (d) chk(wr_last, {adr, r}, "file write");
      reg_chk(3'h0, w);
      reg_chk(3'h1, st);
   endtask

   task automatic tst(input logic [7:0] f, input logic a, tw,
      input logic [11:0] adr, input logic [7:0] m, input int cyc, disc);
      dmem[adr] = m;
      run({`TWSX_OP_TEST_SKIP, a, f}, tw, cyc, disc);
   endtask

   task automatic tbl(input logic [1:0] m, input logic [20:0] p, wa, pe,
      input logic [7:0] l);
      reg_wr(3'h3, l);
      reg_wr(3'h4, p[7:0]);
      reg_wr(3'h5, p[15:8]);
      reg_wr(3'h6, {3'h0, p[20:16]});
      run({`TWSX_OP_TABLE_WR, m}, 1'b0, 9, 0);
      chk(pm_last, {wa, l}, "table write");
      reg_chk(3'h4, pe[7:0]);
      reg_chk(3'h5, pe[15:8]);
      reg_chk(3'h6, {3'h0, pe[20:16]});
      reg_chk(3'h3, l);
   endtask

   task automatic results();
      if (err_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      logic [23:0] lit [3];
      lit = '{24'hAF1A00, 24'h1A0001, 24'h808002};
      repeat (20) @(posedge CLK);
      RESET <= 1'b0;
      for (int i = 0; i < 7; i++)
         reg_chk(i[2:0], 8'h00);
      // literal xor: value, zero and negative results
      reg_wr(3'h0, 8'hB5);
      foreach (lit[i]) begin
         run({`TWSX_OP_XOR_LIT, lit[i][23:16]}, 1'b0, 5, 0);
         reg_chk(3'h0, lit[i][15:8]);
         reg_chk(3'h1, lit[i][7:0]);
      end
      // enable low for three clocks stretches the instruction
      fork
         run({`TWSX_OP_XOR_LIT, 8'h80}, 1'b0, 8, 0);
         begin
            repeat (3) @(posedge CLK);
            CE <= 1'b0;
            repeat (3) @(posedge CLK);
            CE <= 1'b1;
         end
      join
      reg_chk(3'h0, 8'h00);
      reg_chk(3'h1, 8'h01);
      // file xor: low and high access bank, selected bank
      reg_wr(3'h0, 8'hB5);
      reg_wr(3'h2, 8'h03);
      xwf(8'h25, 1, 0, 12'h025, 8'hAF, 8'h1A, 8'hB5, 8'h00);
      xwf(8'h90, 0, 0, 12'hF90, 8'h35, 8'h80, 8'h80, 8'h02);
      xwf(8'h10, 1, 1, 12'h310, 8'h80, 8'h00, 8'h80, 8'h01);
      // zero test leaves the flags alone
      reg_wr(3'h1, 8'h02);
      tst(8'h40, 0, 0, 12'h040, 8'h00, 9, 4);
      tst(8'h40, 0, 1, 12'h040, 8'h00, 13, 8);
      tst(8'h41, 0, 1, 12'h041, 8'h07, 5, 0);
      tst(8'h10, 1, 0, 12'h310, 8'h00, 9, 4);
      tst(8'hC0, 0, 0, 12'hFC0, 8'h00, 9, 4);
      reg_chk(3'h1, 8'h02);
      // table writes in every pointer mode, with wrap
      tbl(2'h1, 21'h00A356, 21'h00A356, 21'h00A357, 8'h55);
      tbl(2'h3, 21'h01389A, 21'h01389B, 21'h01389B, 8'h34);
      tbl(2'h3, 21'h1FFFFF, 21'h000000, 21'h000000, 8'hC3);
      tbl(2'h1, 21'h0FFFFF, 21'h0FFFFF, 21'h100000, 8'h3C);
      tbl(2'h2, 21'h000010, 21'h000010, 21'h00000F, 8'h11);
      tbl(2'h0, 21'h000021, 21'h000021, 21'h000021, 8'h22);
      results();
   end

   // watchdog well beyond the length of the sequence
   initial begin
      repeat (20000) @(posedge CLK);
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      results();
   end
endmodule

// *** verification/twsx_exec_sva.sv ***
// assertion checker for the table write, skip and xor execution unit
`include "twsx_consts.svh"

module twsx_exec_sva (
   // clock, reset and enable
   input logic CLK,
   input logic RESET,
   input logic CE,
   // instruction issue
   input logic INSTR_VALID,
   input logic [15:0] INSTR,
   input logic INSTR_NEXT_TWO_WORD,
   input logic INSTR_READY,
   input logic DISCARD,
   // memories
   input twsx_pkg::twsx_dmem_req_t DMEM_REQ,
   input logic [7:0] DMEM_RDATA,
   input twsx_pkg::twsx_pmem_req_t PMEM_REQ,
   // register port
   input logic [`TWSX_REG_AW-1:0] REG_ADDR,
   input logic [7:0] REG_WDATA,
   input logic REG_WR,
   input logic REG_RD,
   input logic [7:0] REG_RDATA
);
   timeunit 1ns;
   timeprecision 1ns;
   import twsx_pkg::*;

   // ------------------------------------------------------------------
   // opcode decode and shadow state
   // ------------------------------------------------------------------
   logic [15:0] op_r;
   logic [3:0] bank_r;
   logic [7:0] lat_r;
   logic [20:0] ptr_r;
   logic [20:0] ptr_i_r;
   wire issue = INSTR_VALID && INSTR_READY;
   wire is_xlw = INSTR[15:8] == `TWSX_OP_XOR_LIT;
   wire is_xwf = INSTR[15:10] == `TWSX_OP_XOR_FILE;
   wire is_tst = INSTR[15:9] == `TWSX_OP_TEST_SKIP;
   wire is_tbl = INSTR[15:2] == `TWSX_OP_TABLE_WR;
   wire [1:0] mode = INSTR[1:0];
   wire [11:0] f_addr = op_r[8] ? {bank_r, op_r[7:0]} :
      {{4{op_r[7]}}, op_r[7:0]};
   wire [20:0] ptr_nxt = mode == `TWSX_TBL_POSTDEC ? ptr_r - 21'h000001 :
      mode == `TWSX_TBL_NONE ? ptr_r : ptr_r + 21'h000001;

   // opcode and pointer held from the issue edge
   always_ff @(posedge CLK) begin
      if (CE && issue) begin
         op_r <= INSTR;
         ptr_i_r <= ptr_r;
      end
   end

   // bank, latch and pointer as software and execution leave them
   always_ff @(posedge CLK) begin
      if (RESET) begin
         bank_r <= 4'h0;
         lat_r <= 8'h00;
         ptr_r <= 21'h000000;
      end else if (CE && REG_WR) begin
         if (REG_ADDR == 3'h2) bank_r <= REG_WDATA[3:0];
         if (REG_ADDR == 3'h3) lat_r <= REG_WDATA;
         if (REG_ADDR == 3'h4) ptr_r[7:0] <= REG_WDATA;
         if (REG_ADDR == 3'h5) ptr_r[15:8] <= REG_WDATA;
         if (REG_ADDR == 3'h6) ptr_r[20:16] <= REG_WDATA[4:0];
      end else if (CE && issue && is_tbl) begin
         ptr_r <= ptr_nxt;
      end
   end

   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET || !CE);

   property p_xor_cycles;
      issue && (is_xlw || is_xwf) |=> !INSTR_READY [*4] ##1 INSTR_READY;
   endproperty
   a_xor_cycles: assert property (p_xor_cycles)
      else $error("xor did not take one instruction cycle");

   property p_file_addr;
      issue && (is_xwf || is_tst) |-> ##2 DMEM_REQ.rd && DMEM_REQ.addr == f_addr;
   endproperty
   a_file_addr: assert property (p_file_addr)
      else $error("file read at wrong bank or time");

   property p_dest;
      issue && is_xwf |-> ##4 DMEM_REQ.wr == op_r[9] &&
         (!op_r[9] || DMEM_REQ.addr == f_addr);
   endproperty
   a_dest: assert property (p_dest)
      else $error("xor result sent to wrong place");

   property p_lit_quiet;
      issue && is_xlw |=> (!DMEM_REQ.rd && !DMEM_REQ.wr) [*4];
   endproperty
   a_lit_quiet: assert property (p_lit_quiet)
      else $error("literal xor touched data memory");

   property p_skip;
      issue && is_tst && !INSTR_NEXT_TWO_WORD ##3 DMEM_RDATA == 8'h00
         |-> ##2 DISCARD [*4] ##1 INSTR_READY && !DISCARD;
   endproperty
   a_skip: assert property (p_skip)
      else $error("zero test did not discard one cycle");

   property p_no_skip;
      issue && is_tst ##3 DMEM_RDATA != 8'h00 |-> ##1 !DISCARD ##1 INSTR_READY;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("non-zero test skipped");

   property p_skip_two;
      issue && is_tst && INSTR_NEXT_TWO_WORD ##3 DMEM_RDATA == 8'h00
         |-> ##2 DISCARD [*8] ##1 INSTR_READY;
   endproperty
   a_skip_two: assert property (p_skip_two)
      else $error("two-word skip not two no-op cycles");

   property p_post;
      issue && is_tbl && mode == `TWSX_TBL_POSTINC |-> ##[1:8] PMEM_REQ.wr &&
         {PMEM_REQ.word_addr, PMEM_REQ.high_byte} == ptr_i_r &&
         PMEM_REQ.data == lat_r;
   endproperty
   a_post: assert property (p_post)
      else $error("post-increment write at wrong byte");

   property p_pre;
      issue && is_tbl && mode == `TWSX_TBL_PREINC |-> ##[1:8] PMEM_REQ.wr &&
         {PMEM_REQ.word_addr, PMEM_REQ.high_byte} == ptr_i_r + 21'h000001 &&
         PMEM_REQ.data == lat_r;
   endproperty
   a_pre: assert property (p_pre)
      else $error("pre-increment write at wrong byte");

   // main scenarios reached
   c_skip_two: cover property (issue && is_tst && INSTR_NEXT_TWO_WORD);
   c_pre: cover property (issue && is_tbl && mode == `TWSX_TBL_PREINC);
   c_file_wr: cover property (DMEM_REQ.wr);
endmodule

bind twsx_exec twsx_exec_sva twsx_exec_sva_inst (
   .CLK, .RESET, .CE, .INSTR_VALID, .INSTR, .INSTR_NEXT_TWO_WORD,
   .INSTR_READY, .DISCARD, .DMEM_REQ, .DMEM_RDATA, .PMEM_REQ,
   .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA
);
